// >>> logic/tdot_defs.svh
`ifndef TDOT_DEFS_SVH
`define TDOT_DEFS_SVH

// Register indices; the byte address is four times the index
`define TDOT_IDX_MODE      8'h2D
`define TDOT_IDX_SELF      8'h2E
`define TDOT_IDX_THR       8'h2F
`define TDOT_IDX_DUR       8'h30
`define TDOT_IDX_LAT       8'h31
`define TDOT_IDX_WIN       8'h32
`define TDOT_IDX_XOFS      8'h33
`define TDOT_IDX_YOFS      8'h34
`define TDOT_IDX_STAT      8'h40
`define TDOT_IDX_CLR       8'h41
`define TDOT_IDX_IEN       8'h42

`define TDOT_RST_BYTE      8'h00
`define TDOT_RST_MODE      2'h0

`define TDOT_MODE_STANDBY  2'h0
`define TDOT_MODE_MEASURE  2'h2

`define TDOT_SELF_TRIG_BIT 0
`define TDOT_SELF_OVR_BIT  1
`define TDOT_STAT_SGL_BIT  0
`define TDOT_STAT_DBL_BIT  1
`define TDOT_TRIM_W        5

// Timing and scale figures
`define TDOT_CLK_MHZ       25
`define TDOT_DUR_STEP_US   625
`define TDOT_LAT_STEP_MS   1.25
`define TDOT_THR_STEP_MG   62.5
`define TDOT_OFS_STEP_MG   15
`define TDOT_RAW_LSB_MG    0.25
`define TDOT_TRIM_LIMIT    15

`endif

// >>> logic/tdot_pkg.sv
`default_nettype none

package tdot_pkg;

    typedef enum logic [2:0] {
        TDOT_IDLE,
        TDOT_ABOVE,
        TDOT_LATENCY,
        TDOT_WINDOW,
        TDOT_WIN_ABOVE,
        TDOT_WAIT_LOW
    } tdot_state_t;

    typedef logic [7:0] tdot_byte_t;

endpackage : tdot_pkg

`default_nettype wire

// >>> logic/tdot_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "tdot_defs.svh"

// Behaviour
// R01 - Tap threshold: 8-bit unsigned, resets zero
// R02 - Compare tap magnitude, 62.5 mg per step
// R03 - Threshold zero disables single and double tap
// R04 - Tap must end within duration, 625 us units
// R05 - Wait latency, 1.25 ms units, before window
// R06 - Latency zero disables double tap only
// R07 - Double tap needs second tap within window
// R08 - Signed 5-bit X/Y offset, 15 mg step
// R09 - User trim shares factory trim headroom
// R10 - Mode 00 standby, 10 measure, others reserved
// R11 - Sticky status flags for single/double tap
module tdot_top
    import tdot_pkg::*;
#(
    parameter int ADDR_W       = 12,
    parameter int DUR_STEP_CYC = `TDOT_DUR_STEP_US * `TDOT_CLK_MHZ,
    parameter int LAT_STEP_CYC = int'(`TDOT_LAT_STEP_MS * 1000.0 * `TDOT_CLK_MHZ),
    parameter int TRIM_LIMIT   = `TDOT_TRIM_LIMIT
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire logic               sample_valid,
    input  wire logic [13:0]        tap_mag,
    input  wire logic signed [13:0] raw_x,
    input  wire logic signed [13:0] raw_y,
    input  wire logic signed [5:0]  fact_x_trim,
    input  wire logic signed [5:0]  fact_y_trim,
    output var  logic signed [15:0] trim_x,
    output var  logic signed [15:0] trim_y,
    output var  logic               trim_valid,
    output var  logic               selfcheck_trigger,
    output var  logic               selfcheck_override,
    output var  logic               meas_active,
    output var  logic               single_tap,
    output var  logic               double_tap,
    output var  logic               irq
);

    localparam logic [15:0] DUR_LEN = 16'(DUR_STEP_CYC);
    localparam logic [15:0] LAT_LEN = 16'(LAT_STEP_CYC);
    localparam logic [8:0]  THR_GAIN =
        9'(int'(`TDOT_THR_STEP_MG / `TDOT_RAW_LSB_MG));
    localparam logic signed [15:0] OFS_GAIN =
        16'(int'(`TDOT_OFS_STEP_MG / `TDOT_RAW_LSB_MG));
    localparam logic signed [6:0] LIM_HI = 7'(TRIM_LIMIT);
    localparam logic signed [6:0] LIM_LO = -7'(TRIM_LIMIT);

    // Reset asserts at once but releases on sys_clk, after two flops
    logic rst_meta_n_r;
    logic rst_sync_n_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_n_r <= 1'b1;
            rst_sync_n_r <= rst_meta_n_r;
        end
    end

    // Register state
    logic [1:0]   mode_r;
    logic [1:0]   self_r;
    tdot_byte_t   thr_r;
    tdot_byte_t   dur_r;
    tdot_byte_t   lat_r;
    tdot_byte_t   win_r;
    logic [`TDOT_TRIM_W-1:0] xofs_r;
    logic [`TDOT_TRIM_W-1:0] yofs_r;
    logic [1:0]   stat_r;
    logic [1:0]   ien_r;
    logic [31:0]  prdata_r;

    // Bus decode
    wire        setup_ph  = psel & ~penable;
    wire        access_ph = psel & penable;
    wire        wr_en     = access_ph & pwrite;
    wire [7:0]  wbyte     = pwdata[7:0];
    wire        hit_mode  = paddr == ADDR_W'({`TDOT_IDX_MODE, 2'b00});
    wire        hit_self  = paddr == ADDR_W'({`TDOT_IDX_SELF, 2'b00});
    wire        hit_thr   = paddr == ADDR_W'({`TDOT_IDX_THR, 2'b00});
    wire        hit_dur   = paddr == ADDR_W'({`TDOT_IDX_DUR, 2'b00});
    wire        hit_lat   = paddr == ADDR_W'({`TDOT_IDX_LAT, 2'b00});
    wire        hit_win   = paddr == ADDR_W'({`TDOT_IDX_WIN, 2'b00});
    wire        hit_xofs  = paddr == ADDR_W'({`TDOT_IDX_XOFS, 2'b00});
    wire        hit_yofs  = paddr == ADDR_W'({`TDOT_IDX_YOFS, 2'b00});
    wire        hit_stat  = paddr == ADDR_W'({`TDOT_IDX_STAT, 2'b00});
    wire        hit_clr   = paddr == ADDR_W'({`TDOT_IDX_CLR, 2'b00});
    wire        hit_ien   = paddr == ADDR_W'({`TDOT_IDX_IEN, 2'b00});
    wire        hit_any   = hit_mode | hit_self | hit_thr | hit_dur | hit_lat
                          | hit_win | hit_xofs | hit_yofs | hit_stat | hit_clr
                          | hit_ien;

    // Read mux; reserved bits and the clear register read zero
    wire [7:0]  rd_byte =
        hit_mode ? {6'h00, mode_r} :
        hit_self ? {6'h00, self_r} :
        hit_thr  ? thr_r :
        hit_dur  ? dur_r :
        hit_lat  ? lat_r :
        hit_win  ? win_r :
        hit_xofs ? {3'h0, xofs_r} :
        hit_yofs ? {3'h0, yofs_r} :
        hit_stat ? {6'h00, stat_r} :
        hit_ien  ? {6'h00, ien_r} : 8'h00;

    assign pready  = 1'b1;
    assign pslverr = access_ph & ~hit_any;
    assign prdata  = prdata_r;

    always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata_r <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            mode_r <= `TDOT_RST_MODE;
            self_r <= 2'h0;
            thr_r  <= `TDOT_RST_BYTE;
            dur_r  <= `TDOT_RST_BYTE;
            lat_r  <= `TDOT_RST_BYTE;
            win_r  <= `TDOT_RST_BYTE;
            xofs_r <= 5'h00;
            yofs_r <= 5'h00;
            ien_r  <= 2'h0;
        end else if (wr_en) begin
            if (hit_mode) mode_r <= wbyte[1:0];
            if (hit_self) self_r <= wbyte[1:0];
            if (hit_thr)  thr_r  <= wbyte;                       // R01
            if (hit_dur)  dur_r  <= wbyte;
            if (hit_lat)  lat_r  <= wbyte;
            if (hit_win)  win_r  <= wbyte;
            if (hit_xofs) xofs_r <= wbyte[`TDOT_TRIM_W-1:0];     // R08
            if (hit_yofs) yofs_r <= wbyte[`TDOT_TRIM_W-1:0];     // R08
            if (hit_ien)  ien_r  <= wbyte[1:0];
        end
    end

    assign selfcheck_trigger  = self_r[`TDOT_SELF_TRIG_BIT];
    assign selfcheck_override = self_r[`TDOT_SELF_OVR_BIT];

    // Reserved mode codes behave as standby
    assign meas_active = mode_r == `TDOT_MODE_MEASURE;            // R10

    // Tap qualification
    wire [16:0] thr_scaled = 17'(thr_r * THR_GAIN);              // R02
    wire        tap_en     = meas_active & (thr_r != 8'h00);     // R03
    wire        dbl_en     = lat_r != 8'h00;                     // R06

    logic        above_r;
    tdot_state_t state_r;
    tdot_state_t state_nxt;
    logic [15:0] pre_r;
    logic [15:0] pre_nxt;
    logic [8:0]  cnt_r;
    logic [8:0]  cnt_nxt;
    logic        sgl_nxt;
    logic        dbl_nxt;
    logic        sgl_r;
    logic        dbl_r;

    // Magnitude test is refreshed on a new sample and cleared while tap_en is low
    always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            above_r <= 1'b0;
        end else if (!tap_en) begin
            above_r <= 1'b0;
        end else if (sample_valid) begin
            above_r <= {3'h0, tap_mag} > thr_scaled;             // R02
        end
    end

    wire        dur_phase = (state_r == TDOT_ABOVE) | (state_r == TDOT_WIN_ABOVE);
    wire [15:0] step_len  = dur_phase ? DUR_LEN : LAT_LEN;
    wire        tick      = pre_r == step_len - 16'h0001;
    wire [8:0]  cnt_inc   = tick ? cnt_r + 9'h001 : cnt_r;
    wire        too_long  = cnt_r > {1'b0, dur_r};               // R04

    always_comb begin
        state_nxt = state_r;
        pre_nxt   = tick ? 16'h0000 : pre_r + 16'h0001;
        cnt_nxt   = cnt_inc;
        sgl_nxt   = 1'b0;
        dbl_nxt   = 1'b0;
        case (state_r)
            TDOT_IDLE: begin
                if (above_r) begin
                    state_nxt = TDOT_ABOVE;
                end
            end
            TDOT_ABOVE: begin
                if (too_long) begin
                    state_nxt = TDOT_WAIT_LOW;                   // R04
                end else if (!above_r) begin
                    sgl_nxt   = 1'b1;
                    state_nxt = dbl_en ? TDOT_LATENCY : TDOT_IDLE; // R06
                end
            end
            TDOT_LATENCY: begin
                // Leave even if latency was cleared or lowered meanwhile
                if (!dbl_en) begin
                    state_nxt = TDOT_IDLE;                       // R06
                end else if (cnt_inc >= {1'b0, lat_r}) begin
                    state_nxt = TDOT_WINDOW;                     // R05
                end
            end
            TDOT_WINDOW: begin
                if (above_r) begin
                    state_nxt = TDOT_WIN_ABOVE;
                end else if (cnt_inc >= {1'b0, win_r}) begin
                    state_nxt = TDOT_IDLE;                       // R07
                end
            end
            TDOT_WIN_ABOVE: begin
                if (too_long) begin
                    state_nxt = TDOT_WAIT_LOW;                   // R04
                end else if (!above_r) begin
                    dbl_nxt   = 1'b1;                            // R07
                    state_nxt = TDOT_IDLE;
                end
            end
            TDOT_WAIT_LOW: begin
                if (!above_r) begin
                    state_nxt = TDOT_IDLE;
                end
            end
            default: begin
                state_nxt = TDOT_IDLE;
            end
        endcase
        if (!tap_en) begin
            state_nxt = TDOT_IDLE;                               // R03
            sgl_nxt   = 1'b0;
            dbl_nxt   = 1'b0;
        end
        // Each phase starts timing from zero
        if (state_nxt != state_r) begin
            pre_nxt = 16'h0000;
            cnt_nxt = 9'h000;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            state_r <= TDOT_IDLE;
            pre_r   <= 16'h0000;
            cnt_r   <= 9'h000;
            sgl_r   <= 1'b0;
            dbl_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pre_r   <= pre_nxt;
            cnt_r   <= cnt_nxt;
            sgl_r   <= sgl_nxt;
            dbl_r   <= dbl_nxt;
        end
    end

    assign single_tap = sgl_r;
    assign double_tap = dbl_r;

    // Sticky status; a new event beats a clear in the same cycle
    wire [1:0] evt     = {dbl_r, sgl_r};
    wire [1:0] clr_bits = (wr_en & hit_clr) ? wbyte[1:0] : 2'h0;

    always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            stat_r <= 2'h0;
        end else begin
            stat_r <= (stat_r & ~clr_bits) | evt;                // R11
        end
    end

    assign irq = |(stat_r & ien_r);

    // Offset trim per axis
    wire signed [13:0] raw_a  [2];
    wire signed [5:0]  fact_a [2];
    wire [4:0]         user_a [2];
    logic signed [15:0] trim_r [2];

    assign raw_a[0]  = raw_x;
    assign raw_a[1]  = raw_y;
    assign fact_a[0] = fact_x_trim;
    assign fact_a[1] = fact_y_trim;
    assign user_a[0] = xofs_r;
    assign user_a[1] = yofs_r;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_axis
            wire signed [6:0] user_s = {{2{user_a[g][4]}}, user_a[g]};   // R08
            wire signed [6:0] fact_s = {fact_a[g][5], fact_a[g]};
            wire signed [6:0] sum    = fact_s + user_s;
            // Factory and user trim share one clamp
            wire signed [6:0] lim    = (sum > LIM_HI) ? LIM_HI :
                                       (sum < LIM_LO) ? LIM_LO : sum;  // R09
            wire signed [15:0] ofs   = 16'($signed({{9{lim[6]}}, lim}) * OFS_GAIN);
            wire signed [15:0] res   = {{2{raw_a[g][13]}}, raw_a[g]} + ofs;

            always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
                if (!rst_sync_n_r) begin
                    trim_r[g] <= 16'h0000;
                end else if (sample_valid && meas_active) begin
                    trim_r[g] <= res;                            // R08
                end
            end
        end
    endgenerate

    logic tv_r;

    // Valid strobe lines up with the trimmed axis registers
    always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            tv_r <= 1'b0;
        end else begin
            tv_r <= sample_valid & meas_active;                  // R10
        end
    end

    assign trim_x     = trim_r[0];
    assign trim_y     = trim_r[1];
    assign trim_valid = tv_r;

endmodule : tdot_top

`default_nettype wire

// >>> verif/tdot_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tdot_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic sample_valid,
    input wire logic meas_active,
    input wire logic trim_valid,
    input wire logic single_tap,
    input wire logic double_tap,
    input wire logic irq
);
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_meas_smp;
        sample_valid && meas_active;
    endsequence
    property p_from_sample(sig);
        sig |-> $past(sample_valid, 2);
    endproperty
    a_trim_on_meas: assert property (s_meas_smp |=> trim_valid)
        else $error("trim_valid missing");
    a_trim_idle: assert property (!(sample_valid && meas_active) |=> !trim_valid)
        else $error("trim_valid without sample");
    a_standby_quiet: assert property (!meas_active && !$past(meas_active) |-> !single_tap && !double_tap)
        else $error("tap pulse in standby");
    a_single_once: assert property (single_tap |=> !single_tap)
        else $error("single_tap longer than one cycle");
    a_tap_exclusive: assert property (!(single_tap && double_tap))
        else $error("single and double together");
    a_single_cause: assert property (p_from_sample(single_tap))
        else $error("single_tap not after a sample");
    a_double_cause: assert property (p_from_sample(double_tap))
        else $error("double_tap not after a sample");
    a_irq_rise: assert property ($rose(irq) |-> $past(single_tap || double_tap || wr_acc))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr_acc))
        else $error("irq fell without write");
endmodule : tdot_checker

bind tdot_top tdot_checker tdot_checker_i (.sys_clk, .rst_n, .psel, .penable, .pwrite,
    .sample_valid, .meas_active, .trim_valid, .single_tap, .double_tap, .irq);
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "tdot_defs.svh"
module tb_top import tdot_pkg::*; ;
    logic               sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic               sample_valid = 0, tv, er;
    logic        [11:0] paddr = 0;
    logic        [31:0] pwdata = 0, prdata, rd;
    logic        [13:0] tap_mag = 0;
    logic signed [13:0] raw_x = 0, raw_y = 0;
    logic signed [5:0]  fact_x_trim = 0, fact_y_trim = 0;
    logic signed [15:0] trim_x, trim_y;
    logic               pready, pslverr, trim_valid, selfcheck_trigger, selfcheck_override;
    logic               meas_active, single_tap, double_tap, irq;
    int                 bad_count = 0, cmp_count = 0, sc = 0, dc = 0, cyc = 0;

    tdot_top #(.DUR_STEP_CYC(4), .LAT_STEP_CYC(4)) tdot_top_i (.sys_clk, .rst_n, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .sample_valid, .tap_mag, .raw_x,
        .raw_y, .fact_x_trim, .fact_y_trim, .trim_x, .trim_y, .trim_valid, .selfcheck_trigger,
        .selfcheck_override, .meas_active, .single_tap, .double_tap, .irq);

    initial forever #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        sc += int'(single_tap === 1'b1);
        dc += int'(double_tap === 1'b1);
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic samp(input logic [13:0] m);
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        tap_mag <= m;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        #1 tv = trim_valid;
        @(posedge sys_clk);
    endtask : samp

    task automatic tap(input logic [13:0] m);
        samp(m);
        samp(14'h0);
        repeat (4) @(posedge sys_clk);
    endtask : tap

    task automatic t_regs;
        for (int i = 'h2E; i <= 'h34; i++) begin
            apb(0, 8'(i), 0);
            chk("reset", rd, 32'h0);
        end
        apb(1, `TDOT_IDX_THR, 32'hA5);
        apb(0, `TDOT_IDX_THR, 0);
        chk("thr", rd, 32'hA5);
        apb(1, `TDOT_IDX_XOFS, 32'hFF);
        apb(0, `TDOT_IDX_XOFS, 0);
        chk("xofs", rd, 32'h1F);
        apb(1, `TDOT_IDX_SELF, 32'hFF);
        apb(0, `TDOT_IDX_SELF, 0);
        chk("self", {rd[29:0], selfcheck_override, selfcheck_trigger}, 32'hF);
        apb(0, 8'h3F, 0);
        chk("unmapped", 32'({er, rd[7:0]}), 32'h100);
    endtask : t_regs

    task automatic t_mode;
        for (int i = 0; i < 4; i++) begin
            apb(1, `TDOT_IDX_MODE, 32'(i));
            #1 chk("meas", 32'(meas_active), 32'(2'(i) == `TDOT_MODE_MEASURE));
            samp(14'h0);
            chk("tv", 32'(tv), 32'(2'(i) == `TDOT_MODE_MEASURE));
        end
    endtask : t_mode

    task automatic t_trim;
        apb(1, `TDOT_IDX_MODE, 32'h2);
        apb(1, `TDOT_IDX_YOFS, 32'h0F);
        fact_x_trim <= -6'sd20;
        fact_y_trim <= 6'sd5;
        raw_x <= 14'sd100;
        raw_y <= -14'sd100;
        samp(14'h0);
        chk("tx", 32'(trim_x), 32'(-16'sd800));
        chk("ty", 32'(trim_y), 32'(16'sd800));
    endtask : t_trim

    task automatic t_taps;
        apb(1, `TDOT_IDX_THR, 1);
        apb(1, `TDOT_IDX_DUR, 2);
        apb(1, `TDOT_IDX_LAT, 1);
        apb(1, `TDOT_IDX_WIN, 4);
        apb(1, `TDOT_IDX_IEN, 3);
        tap(14'd250);
        chk("edge", sc, 0);
        tap(14'd251);
        tap(14'd251);
        chk("sgl", sc, 1);
        chk("dbl", dc, 1);
        apb(0, `TDOT_IDX_STAT, 0);
        chk("stat", {rd[30:0], irq}, 32'h7);
        apb(1, `TDOT_IDX_IEN, 0);
        #1 chk("mask", 32'(irq), 0);
        apb(1, `TDOT_IDX_IEN, 3);
        apb(1, `TDOT_IDX_CLR, 3);
        apb(0, `TDOT_IDX_STAT, 0);
        chk("clr", {rd[30:0], irq}, 32'h0);
        tap(14'd300);
        repeat (30) @(posedge sys_clk);
        tap(14'd300);
        repeat (30) @(posedge sys_clk);
        chk("late", {sc[15:0], dc[15:0]}, 32'h30001);
        apb(1, `TDOT_IDX_DUR, 1);
        samp(14'd300);
        repeat (12) @(posedge sys_clk);
        tap(14'h0);
        chk("long", sc, 3);
        apb(1, `TDOT_IDX_DUR, 2);
        apb(1, `TDOT_IDX_LAT, 0);
        tap(14'd300);
        tap(14'd300);
        chk("nolat", {sc[15:0], dc[15:0]}, 32'h50001);
        apb(1, `TDOT_IDX_THR, 0);
        tap(14'd300);
        chk("thr0", sc, 5);
        apb(1, `TDOT_IDX_THR, 1);
        apb(1, `TDOT_IDX_MODE, 0);
        tap(14'd300);
        chk("stby", sc, 5);
    endtask : t_taps

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_regs();
        t_mode();
        t_trim();
        t_taps();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
